// ### design/prhg_pkg.sv
// Shared constants and types for the physical RNG health gate
package prhg_pkg;
    localparam int TOT_RUN    = 16;  // Equal bits in a row that mean a dead source
    localparam int WIN_BITS   = 256; // Raw bits per online test window
    localparam int ONES_LO    = 96;  // Least count of ones in a passing window
    localparam int ONES_HI    = 160; // Greatest count of ones in a passing window
    localparam int CHUNK_BITS = 16;  // Raw bits gathered per output word
    localparam int WORD_W     = 16;  // Widest output word
    localparam int BYTE_W     = 8;   // Narrow output word
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        PRHG_IDLE = 2'h0,
        PRHG_BOOT = 2'h1,
        PRHG_RUN  = 2'h3,
        PRHG_FAIL = 2'h2
    } prhg_state_t;
endpackage

// ### design/prhg_fifo_if.sv
// Word channel between the health gate and its output FIFO
`timescale 1ns/1ps
interface prhg_fifo_if #(parameter int W = 16);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;
    logic         flush;

    modport src  (output wr_valid, wr_data, rd_ready, flush,
                  input  wr_ready, rd_valid, rd_data);
    modport fifo (input  wr_valid, wr_data, rd_ready, flush,
                  output wr_ready, rd_valid, rd_data);
endinterface

// ### design/prhg_fifo.sv
// Small flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
module prhg_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Channel
    prhg_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } prhg_fifo_st_t;

    prhg_fifo_st_t s;
    prhg_fifo_st_t next_s;
    logic          do_wr;
    logic          do_rd;

    assign f.wr_ready = (s.cnt != (AW+1)'(DEPTH)) && !f.flush;
    assign f.rd_valid = (s.cnt != '0) && !f.flush;
    assign f.rd_data  = s.mem[s.rp];
    assign do_wr      = f.wr_valid && f.wr_ready;
    assign do_rd      = f.rd_valid && f.rd_ready;

    always_comb
    begin
        next_s = s;
        if (f.flush)
        begin
            next_s.wp  = '0;
            next_s.rp  = '0;
            next_s.cnt = '0;
        end
        else
        begin
            if (do_wr)
            begin
                next_s.mem[s.wp] = f.wr_data;
                next_s.wp        = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + AW'(1);
            end
            if (do_rd)
                next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + AW'(1);
            next_s.cnt = s.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
            s <= '0;
        else
            s <= next_s;
    end
endmodule // prhg_fifo

// ### design/prhg_top.sv
// Health gate around a physical entropy source with word output
// Operation
// R1 - A total-failure check runs on the raw bits from the moment the generator starts.
// R2 - After a total failure is seen no random word is delivered any more.
// R3 - Words that hold raw bits produced after a total failure never reach the reader.
// R4 - A statistical online test runs on the raw bits at start-up and throughout operation.
// R5 - No output until the power-up online test passes, and none once a defect is flagged.
// R6 - The online test is retriggered window after window so defects are caught soon.
// R7 - Random data reaches the reader as 8-bit or 16-bit words.
// R8 - The internal bits must carry an average Shannon entropy per bit above 0.997; the code only bounds the count of ones in each window.
// R9 - Status outputs tell apart a total source failure and an online-test defect.
`timescale 1ns/1ps
module prhg_top #(
    parameter int TOT_RUN  = prhg_pkg::TOT_RUN,
    parameter int WIN_BITS = prhg_pkg::WIN_BITS,
    parameter int ONES_LO  = prhg_pkg::ONES_LO,
    parameter int ONES_HI  = prhg_pkg::ONES_HI,
    parameter int DEPTH    = prhg_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                        CLK,
    input  wire logic                        SRST,
    // Control
    input  wire logic                        RNG_START,
    input  wire logic                        WORD_16,
    // Raw entropy stream
    input  wire logic                        RAW_BIT,
    input  wire logic                        RAW_VALID,
    output logic                             RAW_READY,
    // Word output
    output logic                             RD_VALID,
    input  wire logic                        RD_READY,
    output logic [prhg_pkg::WORD_W-1:0]      RD_DATA,
    // Status
    output logic                             HEALTH_OK,
    output logic                             FAIL_TOTAL,
    output logic                             FAIL_STAT
);
    localparam int RW = $clog2(TOT_RUN + 1);
    localparam int WW = $clog2(WIN_BITS);
    localparam int OW = $clog2(WIN_BITS + 1);
    localparam int CB = prhg_pkg::CHUNK_BITS;
    localparam int CW = $clog2(CB);

    typedef struct packed {
        prhg_pkg::prhg_state_t   state;
        logic [RW-1:0]           run_len;
        logic                    last_bit;
        logic [WW-1:0]           win_cnt;
        logic [OW-1:0]           ones;
        logic [CB-1:0]           chunk;
        logic [CW-1:0]           chunk_cnt;
        logic [CB-1:0]           pend;
        logic                    pend_ok;
        logic                    fail_tot;
        logic                    fail_stat;
    } prhg_st_t;

    prhg_st_t              s;
    prhg_st_t              next_s;
    logic                  take;
    logic                  chunk_end;
    logic                  win_end;
    logic                  win_bad;
    logic                  push;
    logic [OW-1:0]         ones_now;
    logic [CB-1:0]         chunk_now;
    logic [prhg_pkg::WORD_W-1:0] push_word;

    prhg_fifo_if #(.W(prhg_pkg::WORD_W)) f ();

    prhg_fifo #(
        .W     (prhg_pkg::WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .CLK   (CLK),
        .SRST  (SRST),
        .f     (f)
    );

    // The held word leaves only when the chunk after it ends; stall the
    // source rather than lose a checked word when the FIFO is full.
    assign chunk_end = (s.chunk_cnt == CW'(CB-1));
    // Only a push can be refused by a full FIFO; words left over from an
    // earlier run must not stall the power-up test, which cannot drain them
    assign RAW_READY = (s.state == prhg_pkg::PRHG_BOOT || s.state == prhg_pkg::PRHG_RUN)
                       && RNG_START
                       && !(chunk_end && s.pend_ok && s.state == prhg_pkg::PRHG_RUN
                            && !f.wr_ready);
    assign take      = RAW_VALID && RAW_READY;
    assign win_end   = (s.win_cnt == WW'(WIN_BITS-1));
    assign ones_now  = s.ones + OW'(RAW_BIT);
    assign chunk_now = {s.chunk[CB-2:0], RAW_BIT};
    // Monobit bounds guard the entropy of the raw bits (see R8)
    assign win_bad   = (ones_now < OW'(ONES_LO)) || (ones_now > OW'(ONES_HI));

    always_comb
    begin
        next_s    = s;
        push      = 1'b0;
        push_word = '0;
        case (s.state)
            prhg_pkg::PRHG_IDLE:
            begin
                if (RNG_START)
                begin
                    next_s.state     = prhg_pkg::PRHG_BOOT;
                    next_s.run_len   = '0;
                    next_s.win_cnt   = '0;
                    next_s.ones      = '0;
                    next_s.chunk_cnt = '0;
                    next_s.pend_ok   = 1'b0;
                end
            end
            prhg_pkg::PRHG_BOOT, prhg_pkg::PRHG_RUN:
            begin
                if (!RNG_START)
                begin
                    next_s.state   = prhg_pkg::PRHG_IDLE;
                    next_s.pend_ok = 1'b0;
                end
                else if (take)
                begin
                    // Stuck-bit run detector from the first bit on (see R1)
                    if (s.run_len != '0 && RAW_BIT == s.last_bit)
                        next_s.run_len = s.run_len + RW'(1);
                    else
                        next_s.run_len = RW'(1);
                    next_s.last_bit = RAW_BIT;
                    if (next_s.run_len == RW'(TOT_RUN))
                        next_s.fail_tot = 1'b1; // see R1
                    // Window test, restarted back to back (see R4, R6)
                    next_s.ones    = ones_now;
                    next_s.win_cnt = s.win_cnt + WW'(1);
                    if (win_end)
                    begin
                        next_s.win_cnt = '0;
                        next_s.ones    = '0;
                        if (win_bad)
                            next_s.fail_stat = 1'b1; // see R4
                        else if (s.state == prhg_pkg::PRHG_BOOT)
                            next_s.state = prhg_pkg::PRHG_RUN; // see R5
                    end
                    // A word is held for one further chunk: any stuck run
                    // that began inside it is then long enough to trip
                    // the detector before the word is released (see R3)
                    next_s.chunk     = chunk_now;
                    next_s.chunk_cnt = s.chunk_cnt + CW'(1);
                    if (chunk_end)
                    begin
                        next_s.chunk_cnt = '0;
                        if (s.pend_ok && s.state == prhg_pkg::PRHG_RUN
                            && !next_s.fail_tot && !next_s.fail_stat)
                        begin
                            push = 1'b1; // see R2, R3, R5
                            if (WORD_16)
                                push_word = s.pend; // see R7
                            else
                                push_word = {{(prhg_pkg::WORD_W-prhg_pkg::BYTE_W){1'b0}},
                                             s.pend[prhg_pkg::BYTE_W-1:0]}; // see R7
                        end
                        next_s.pend    = chunk_now;
                        next_s.pend_ok = 1'b1;
                    end
                    if (next_s.fail_tot || next_s.fail_stat)
                    begin
                        next_s.state   = prhg_pkg::PRHG_FAIL; // see R2, R5
                        next_s.pend_ok = 1'b0;
                    end
                end
            end
            prhg_pkg::PRHG_FAIL:
            begin
                // Only a reset leaves here; a restart could leak a bad source
                next_s.pend_ok = 1'b0;
            end
            default:
            begin
                next_s.state = prhg_pkg::PRHG_FAIL;
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
            s <= '0;
        else
            s <= next_s;
    end

    assign f.wr_valid  = push;
    assign f.wr_data   = push_word;
    assign f.flush     = (s.state == prhg_pkg::PRHG_FAIL); // see R2, R3
    assign f.rd_ready  = RD_READY && (s.state == prhg_pkg::PRHG_RUN);
    assign RD_VALID    = f.rd_valid && (s.state == prhg_pkg::PRHG_RUN); // see R5
    assign RD_DATA     = f.rd_data;
    assign HEALTH_OK   = (s.state == prhg_pkg::PRHG_RUN);
    assign FAIL_TOTAL  = s.fail_tot;  // see R9
    assign FAIL_STAT   = s.fail_stat; // see R9

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    property p_tot_trip;
        $rose(s.fail_tot) |-> $past(s.run_len) == RW'(TOT_RUN-1) && $past(take);
    endproperty
    a_tot_trip: assert property (p_tot_trip) else $error("total fail without full run"); // see R1

    property p_tot_silent;
        s.fail_tot |-> !RD_VALID && !push;
    endproperty
    a_tot_silent: assert property (p_tot_silent) else $error("word after total fail"); // see R2

    property p_fail_flush;
        (s.fail_tot || s.fail_stat) |-> ##1 !f.rd_valid [*2];
    endproperty
    a_fail_flush: assert property (p_fail_flush) else $error("fifo not emptied on fail"); // see R3

    property p_stat_trip;
        (take && win_end && win_bad && s.state != prhg_pkg::PRHG_IDLE) |=> s.fail_stat;
    endproperty
    a_stat_trip: assert property (p_stat_trip) else $error("bad window missed"); // see R4

    property p_boot_gate;
        $rose(HEALTH_OK) |-> $past(win_end) && $past(take) && !s.fail_stat;
    endproperty
    a_boot_gate: assert property (p_boot_gate) else $error("run before passing window"); // see R5

    property p_no_out_unhealthy;
        !HEALTH_OK |-> !RD_VALID;
    endproperty
    a_no_out_unhealthy: assert property (p_no_out_unhealthy) else $error("output while unhealthy"); // see R5

    property p_window_restart;
        (take && win_end && !s.fail_tot && RNG_START) |=> s.win_cnt == '0 && s.ones == '0;
    endproperty
    a_window_restart: assert property (p_window_restart) else $error("window not restarted"); // see R6

    property p_byte_word;
        (push && !WORD_16) |-> push_word[prhg_pkg::WORD_W-1:prhg_pkg::BYTE_W] == '0;
    endproperty
    a_byte_word: assert property (p_byte_word) else $error("byte word has high bits"); // see R7

    property p_flags_sticky;
        (FAIL_TOTAL || FAIL_STAT) |=> $stable({FAIL_TOTAL, FAIL_STAT}) || $rose(FAIL_TOTAL)
                                     || $rose(FAIL_STAT);
    endproperty
    a_flags_sticky: assert property (p_flags_sticky) else $error("fail flag dropped"); // see R9

    // The counters behind both tests must step once per taken bit; a
    // skipped step would let a stuck or biased source slip past them
    property p_run_count;
        (take && s.run_len != '0 && RAW_BIT == s.last_bit)
            |=> s.run_len == $past(s.run_len) + RW'(1);
    endproperty
    a_run_count: assert property (p_run_count) else $error("run length skipped"); // see R1

    property p_run_bound;
        s.run_len <= RW'(TOT_RUN);
    endproperty
    a_run_bound: assert property (p_run_bound) else $error("run length past limit"); // see R1

    property p_fail_hold;
        (s.state == prhg_pkg::PRHG_FAIL) |=> (s.state == prhg_pkg::PRHG_FAIL);
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("fail state left"); // see R2

    property p_fail_no_raw;
        (FAIL_TOTAL || FAIL_STAT) |-> !RAW_READY;
    endproperty
    a_fail_no_raw: assert property (p_fail_no_raw) else $error("raw bit after fail"); // see R3

    property p_ones_count;
        (take && !win_end) |=> s.ones == $past(ones_now);
    endproperty
    a_ones_count: assert property (p_ones_count) else $error("ones count skipped"); // see R4

    property p_stat_silent;
        s.fail_stat |-> !RD_VALID && !push;
    endproperty
    a_stat_silent: assert property (p_stat_silent) else $error("word after defect"); // see R5

    property p_boot_silent;
        (s.state == prhg_pkg::PRHG_BOOT) |-> !RD_VALID && !push;
    endproperty
    a_boot_silent: assert property (p_boot_silent) else $error("word during boot"); // see R5

    property p_win_step;
        (take && !win_end) |=> s.win_cnt == $past(s.win_cnt) + WW'(1);
    endproperty
    a_win_step: assert property (p_win_step) else $error("window count skipped"); // see R6

    property p_push_room;
        push |-> f.wr_ready;
    endproperty
    a_push_room: assert property (p_push_room) else $error("checked word dropped"); // see R7

    property p_word_full;
        (push && WORD_16) |-> push_word == s.pend;
    endproperty
    a_word_full: assert property (p_word_full) else $error("wide word mangled"); // see R7

    property p_fail_status;
        (FAIL_TOTAL || FAIL_STAT) |-> !HEALTH_OK;
    endproperty
    a_fail_status: assert property (p_fail_status) else $error("healthy while failed"); // see R9
endmodule // prhg_top

// ### test/prhg_host_model.sv
// Reader model standing in for the processor that takes random words
`timescale 1ns/1ps
module prhg_host_model (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // Word channel
    input  wire logic                       rd_valid,
    output logic                            rd_ready = 1'b0,
    input  wire logic [prhg_pkg::WORD_W-1:0] rd_data,
    // Pacing from the bench
    input  wire logic                       stall
);
    logic [prhg_pkg::WORD_W-1:0] rx_q [$];

    // Ready changes only after an edge, so a stall never cuts a word in half
    always @(posedge clk)
    begin
        if (rd_valid && rd_ready && !srst)
            rx_q.push_back(rd_data);
        rd_ready <= !stall && !srst;
    end
endmodule // prhg_host_model

// ### test/prhg_top_tb.sv
// Self-checking bench for the RNG health gate
`timescale 1ns/1ps
module prhg_top_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        rng_start = 1'b0;
    logic        word_16 = 1'b1;
    logic        raw_bit = 1'b0;
    logic        raw_valid = 1'b0;
    logic        raw_ready;
    logic        rd_valid;
    logic        rd_ready;
    logic [15:0] rd_data;
    logic        health_ok;
    logic        fail_total;
    logic        fail_stat;
    logic        stall = 1'b0;
    int          err_count = 0;
    int          checks_done = 0;
    logic [15:0] pat [4] = '{16'h5A5A, 16'hA5C3, 16'h3C96, 16'h69E1};
    wire  [4:0]  flags = {raw_ready, rd_valid, health_ok, fail_total, fail_stat};

    always #10 clk = ~clk;

    // Short window keeps the run brief; pass bounds 8 to 24 are looser than the scaled 12 to 20
    prhg_top #(.TOT_RUN(16), .WIN_BITS(32), .ONES_LO(8), .ONES_HI(24), .DEPTH(4)) dut_u (
        .CLK(clk), .SRST(srst), .RNG_START(rng_start), .WORD_16(word_16),
        .RAW_BIT(raw_bit), .RAW_VALID(raw_valid), .RAW_READY(raw_ready),
        .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
        .HEALTH_OK(health_ok), .FAIL_TOTAL(fail_total), .FAIL_STAT(fail_stat));

    prhg_host_model host_u (.clk(clk), .srst(srst), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .stall(stall));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; holds each bit until it is taken
    task automatic send(input logic [15:0] w, input bit last);
        int n;
        for (int i = 15; i >= 0; i--)
        begin
            raw_valid <= 1'b1;
            raw_bit   <= w[i];
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end while (!raw_ready && n < 200);
            // A bit that is never taken is a stall the scenario did not expect
            if (!raw_ready)
                err_count++;
            @(posedge clk);
        end
        if (last)
            raw_valid <= 1'b0;
    endtask

    task automatic do_reset();
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
    endtask

    task automatic t_boot();
        do_reset();
        chk(16'(flags), 16'h00);
        @(posedge clk);
        rng_start <= 1'b1;
        send(pat[0], 1'b0);
        send(pat[1], 1'b1);
        @(negedge clk);
        chk(16'(flags), 16'h14);
        $display("test boot done");
    endtask

    // Reader stalls until the FIFO and the held word back up the raw stream
    task automatic t_fill();
        @(posedge clk);
        stall <= 1'b1;
        for (int k = 2; k < 6; k++)
            send(pat[k % 4], 1'b0);
        fork
            send(pat[2], 1'b1);
            begin
                repeat (40) @(negedge clk);
                chk(16'(flags), 16'h0C);
                @(posedge clk);
                stall <= 1'b0;
            end
        join
        repeat (10) @(negedge clk);
        chk(16'(host_u.rx_q.size()), 16'h0005);
        for (int k = 1; k < 6; k++)
            chk(host_u.rx_q[k-1], pat[k % 4]);
        chk(16'(rd_valid), 16'h0000);
        $display("test fill done");
    endtask

    task automatic t_byte();
        @(posedge clk);
        word_16 <= 1'b0;
        send(pat[3], 1'b1);
        repeat (4) @(negedge clk);
        chk(host_u.rx_q[5], {8'h00, pat[2][7:0]});
        $display("test byte done");
    endtask

    // Dropping the start input parks the gate; a restart reruns the power-up window
    task automatic t_restart();
        @(posedge clk);
        rng_start <= 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(flags), 16'h00);
        @(posedge clk);
        rng_start <= 1'b1;
        send(pat[0], 1'b0);
        send(pat[1], 1'b1);
        @(negedge clk);
        chk(16'(flags), 16'h14);
        $display("test restart done");
    endtask

    // The zeros follow a word that ends in a one, so the run is exactly 16;
    // a word parked in the FIFO by the stalled reader must be thrown away
    task automatic t_total();
        @(posedge clk);
        stall <= 1'b1;
        send(pat[3], 1'b1);
        @(negedge clk);
        chk(16'(rd_valid), 16'h0001);
        chk(rd_data, {8'h00, pat[1][7:0]});
        @(posedge clk);
        send(16'h0000, 1'b1);
        @(negedge clk);
        chk(16'(flags), 16'h02);
        @(posedge clk);
        stall <= 1'b0;
        repeat (10) @(negedge clk);
        chk(16'(host_u.rx_q.size()), 16'h0006);
        $display("test total done");
    endtask

    task automatic t_stat();
        @(posedge clk);
        do_reset();
        chk(16'(flags), 16'h00);
        @(posedge clk);
        send(16'h0101, 1'b0);
        send(16'h0101, 1'b1);
        @(negedge clk);
        chk(16'(flags), 16'h01);
        @(posedge clk);
        do_reset();
        @(posedge clk);
        send(16'hFFFF, 1'b1);
        @(negedge clk);
        chk(16'(flags), 16'h02);
        $display("test stat done");
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        @(posedge clk);
        t_boot();
        t_fill();
        t_byte();
        t_restart();
        t_total();
        t_stat();
        results();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        #60000;
        err_count++;
        results();
    end
endmodule // prhg_top_tb
